/* mpm_space_map.sv */
// program memory space map: size registers, decoder and bus slave
`timescale 1ns/10ps
module mpm_space_map
  import mpm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] cpuAddr,
  input wire logic cpuReq,
  input wire logic cpuWr,
  output logic [2:0] cpuRegion,
  output logic [5:0] cpuBlock,
  output logic cpuInRom,
  output logic cpuVecHit,
  output logic [4:0] cpuVecIdx,
  output logic cpuVecHigh,
  output logic cpuResetVec,
  output logic cpuOneByteTableCallHit,
  output logic [4:0] cpuOneByteTableCallIdx,
  output logic cpuOptHit,
  output logic cpuTwoByteDirectCallOk,
  output logic [15:0] cpuPhysAddr,
  output logic cpuWrRefused,
  output logic sizeOverlap
);

  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } mpm_bus_e;

  typedef struct packed {
    logic [7:0] romSel;
    logic [7:0] ramSel;
    logic [1:0] ctrl;
    logic sticky;
    logic [7:0] refCnt;
    mpm_bus_e wst;
    logic awHave;
    logic wHave;
    logic [11:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [2:0] region;
    logic [5:0] block;
    logic inRom;
    logic vecHit;
    logic [4:0] vecIdx;
    logic vecHigh;
    logic resetVec;
    logic oneByteTableCallHit;
    logic [4:0] oneByteTableCallIdx;
    logic optHit;
    logic twoByteDirectCallOk;
    logic [15:0] physAddr;
    logic wrRefused;
    logic overlap;
  } mpm_state_s;

  localparam mpm_state_s ST_RST = '{
    romSel: ROM_SIZE_RST,
    ramSel: RAM_SIZE_RST,
    ctrl: CTRL_RST,
    sticky: 1'b0,
    refCnt: REFUSED_RST,
    wst: BUS_IDLE,
    awHave: 1'b0,
    wHave: 1'b0,
    awAddr: 12'h000,
    wData: 32'h0000_0000,
    wStrb: 4'h0,
    awready: 1'b1,
    wready: 1'b1,
    bvalid: 1'b0,
    bresp: RESP_OKAY,
    arready: 1'b1,
    rvalid: 1'b0,
    rresp: RESP_OKAY,
    rdata: 32'h0000_0000,
    region: RG_NONE,
    block: 6'h00,
    inRom: 1'b0,
    vecHit: 1'b0,
    vecIdx: 5'h00,
    vecHigh: 1'b0,
    resetVec: 1'b0,
    oneByteTableCallHit: 1'b0,
    oneByteTableCallIdx: 5'h00,
    optHit: 1'b0,
    twoByteDirectCallOk: 1'b0,
    physAddr: 16'h0000,
    wrRefused: 1'b0,
    overlap: 1'b0
  };

  mpm_state_s s_q;
  mpm_state_s s_d;
  mpm_dec_if dif ();

  // ---------------------------------------------------------------
  // address decoder
  // ---------------------------------------------------------------
  assign dif.addr = cpuAddr;
  assign dif.romSel = s_q.romSel;
  assign dif.ramSel = s_q.ramSel;
  assign dif.swapOn = s_q.ctrl[CTRL_SWAP_BIT];
  assign dif.protectOn = s_q.ctrl[CTRL_PROTECT_BIT];

  mpm_addr_decode u_dec (
    .dif(dif)
  );

  // ---------------------------------------------------------------
  // register read mux
  // ---------------------------------------------------------------
  function automatic logic [31:0] readWord(input mpm_state_s st, input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      OFS_ROM_SIZE: v = {24'h000000, st.romSel};
      OFS_RAM_SIZE: v = {24'h000000, st.ramSel};
      OFS_CTRL: v = {30'h0000_0000, st.ctrl};
      OFS_STATUS: v = {14'h0000, st.overlap, st.sticky, 5'h00, st.region, 2'h0, st.block};
      OFS_REFUSED: v = {24'h000000, st.refCnt};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return a == OFS_ROM_SIZE || a == OFS_RAM_SIZE || a == OFS_CTRL
      || a == OFS_STATUS || a == OFS_REFUSED;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic stickyClr;
    logic blocked;
    stickyClr = 1'b0;
    blocked = 1'b0;
    s_d = s_q;

    // -------------------------------------------------------------
    // write address and data, taken in either order
    // -------------------------------------------------------------
    if (s_q.awready && s_axi_awvalid) begin
      s_d.awHave = 1'b1;
      s_d.awAddr = s_axi_awaddr;
      s_d.awready = 1'b0;
    end
    if (s_q.wready && s_axi_wvalid) begin
      s_d.wHave = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
      s_d.wready = 1'b0;
    end

    case (s_q.wst)
      BUS_IDLE: begin
        if (s_d.awHave && s_d.wHave) begin
          s_d.awHave = 1'b0;
          s_d.wHave = 1'b0;
          s_d.bvalid = 1'b1;
          s_d.bresp = mapped(s_d.awAddr) ? RESP_OKAY : RESP_SLVERR;
          s_d.wst = BUS_RESP;
          case (s_d.awAddr)
            OFS_ROM_SIZE: begin
              if (s_d.wStrb[0]) begin
                s_d.romSel = s_d.wData[7:0];
              end
            end
            OFS_RAM_SIZE: begin
              if (s_d.wStrb[0]) begin
                s_d.ramSel = s_d.wData[7:0];
              end
            end
            OFS_CTRL: begin
              if (s_d.wStrb[0]) begin
                s_d.ctrl = s_d.wData[1:0];
              end
            end
            OFS_STATUS: begin
              stickyClr = s_d.wStrb[2] && s_d.wData[STAT_STICKY_BIT];
            end
            OFS_REFUSED: begin
              if (s_d.wStrb[0]) begin
                s_d.refCnt = 8'h00;
              end
            end
            default: begin
            end
          endcase
        end
      end
      BUS_RESP: begin
        if (s_axi_bready) begin
          s_d.bvalid = 1'b0;
          s_d.awready = 1'b1;
          s_d.wready = 1'b1;
          s_d.wst = BUS_IDLE;
        end
      end
      default: begin
        s_d.wst = BUS_IDLE;
        s_d.awready = 1'b1;
        s_d.wready = 1'b1;
        s_d.bvalid = 1'b0;
      end
    endcase

    // -------------------------------------------------------------
    // read channel, one read at a time
    // -------------------------------------------------------------
    if (s_q.arready && s_axi_arvalid) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rdata = readWord(s_q, s_axi_araddr);
      s_d.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end

    // -------------------------------------------------------------
    // cpu access decode, registered on each request
    // -------------------------------------------------------------
    if (cpuReq) begin
      s_d.region = dif.region;
      s_d.block = dif.block;
      s_d.inRom = dif.inRom;
      s_d.vecHit = dif.vecHit;
      s_d.vecIdx = dif.vecIdx;
      s_d.vecHigh = dif.vecHigh;
      s_d.resetVec = dif.resetVec;
      s_d.oneByteTableCallHit = dif.oneByteTableCallHit;
      s_d.oneByteTableCallIdx = dif.oneByteTableCallIdx;
      s_d.optHit = dif.optHit;
      s_d.twoByteDirectCallOk = dif.twoByteDirectCallOk;
      s_d.physAddr = dif.physAddr;
    end
    s_d.overlap = dif.overlap;

    // -------------------------------------------------------------
    // boot cluster zero write protection
    // -------------------------------------------------------------
    blocked = cpuReq && cpuWr && dif.bootHit && dif.protectOn;
    s_d.wrRefused = blocked;
    if (stickyClr) begin
      s_d.sticky = 1'b0;
    end
    if (blocked) begin
      s_d.sticky = 1'b1;
      if (s_d.refCnt != 8'hff) begin
        s_d.refCnt = s_d.refCnt + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign cpuRegion = s_q.region;
  assign cpuBlock = s_q.block;
  assign cpuInRom = s_q.inRom;
  assign cpuVecHit = s_q.vecHit;
  assign cpuVecIdx = s_q.vecIdx;
  assign cpuVecHigh = s_q.vecHigh;
  assign cpuResetVec = s_q.resetVec;
  assign cpuOneByteTableCallHit = s_q.oneByteTableCallHit;
  assign cpuOneByteTableCallIdx = s_q.oneByteTableCallIdx;
  assign cpuOptHit = s_q.optHit;
  assign cpuTwoByteDirectCallOk = s_q.twoByteDirectCallOk;
  assign cpuPhysAddr = s_q.physAddr;
  assign cpuWrRefused = s_q.wrRefused;
  assign sizeOverlap = s_q.overlap;

endmodule // mpm_space_map

/* mpm_pkg.sv */
// constants shared by the program memory space map files
package mpm_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int AXI_AW = 12;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_ROM_SIZE = 12'h000;
  localparam logic [11:0] OFS_RAM_SIZE = 12'h004;
  localparam logic [11:0] OFS_CTRL = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [11:0] OFS_REFUSED = 12'h010;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [7:0] ROM_SIZE_RST = 8'hcf;
  localparam logic [7:0] RAM_SIZE_RST = 8'h0c;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [7:0] REFUSED_RST = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_PROTECT_BIT = 0;
  localparam int CTRL_SWAP_BIT = 1;
  localparam int STAT_STICKY_BIT = 16;
  localparam int ROM_UNIT_SH = 12;
  localparam int RAM_UNIT_SH = 9;
  localparam int BLOCK_SH = 10;

  // ---------------------------------------------------------------
  // fixed address regions
  // ---------------------------------------------------------------
  localparam logic [3:0] RAM_SEL_NONE = 4'hc;
  localparam logic [15:0] VEC_TOP = 16'h003f;
  localparam logic [15:0] ONE_BYTE_TABLE_CALL_LO = 16'h0040;
  localparam logic [15:0] ONE_BYTE_TABLE_CALL_TOP = 16'h007f;
  localparam logic [15:0] OPT_LO = 16'h0080;
  localparam logic [15:0] OPT_TOP = 16'h0084;
  localparam logic [15:0] OPT_SWAP_LO = 16'h1080;
  localparam logic [15:0] OPT_SWAP_TOP = 16'h1084;
  localparam logic [15:0] TWO_BYTE_DIRECT_CALL_LO = 16'h0800;
  localparam logic [15:0] TWO_BYTE_DIRECT_CALL_TOP = 16'h0fff;
  localparam logic [15:0] BOOT0_TOP = 16'h0fff;
  localparam logic [15:0] SWAP_TOP = 16'h1fff;
  localparam logic [15:0] RAM_END = 16'hf7ff;
  localparam logic [15:0] RAM_CEIL = 16'hf800;
  localparam logic [15:0] HRAM_LO = 16'hfb00;
  localparam logic [15:0] HRAM_TOP = 16'hfeff;
  localparam logic [15:0] SFR_LO = 16'hff00;

  // ---------------------------------------------------------------
  // region codes
  // ---------------------------------------------------------------
  localparam logic [2:0] RG_NONE = 3'h0;
  localparam logic [2:0] RG_ROM = 3'h1;
  localparam logic [2:0] RG_XRAM = 3'h2;
  localparam logic [2:0] RG_HRAM = 3'h3;
  localparam logic [2:0] RG_SFR = 3'h4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* mpm_dec_if.sv */
// signals between the register side and the address decoder
`timescale 1ns/10ps
interface mpm_dec_if;
  logic [15:0] addr;
  logic [7:0] romSel;
  logic [7:0] ramSel;
  logic swapOn;
  logic protectOn;
  logic [2:0] region;
  logic [5:0] block;
  logic inRom;
  logic vecHit;
  logic [4:0] vecIdx;
  logic vecHigh;
  logic resetVec;
  logic oneByteTableCallHit;
  logic [4:0] oneByteTableCallIdx;
  logic optHit;
  logic twoByteDirectCallOk;
  logic [15:0] physAddr;
  logic bootHit;
  logic overlap;
  modport dec (input addr, romSel, ramSel, swapOn, protectOn,
    output region, block, inRom, vecHit, vecIdx, vecHigh, resetVec, oneByteTableCallHit,
    oneByteTableCallIdx, optHit, twoByteDirectCallOk, physAddr, bootHit, overlap);
  modport user (output addr, romSel, ramSel, swapOn, protectOn,
    input region, block, inRom, vecHit, vecIdx, vecHigh, resetVec, oneByteTableCallHit,
    oneByteTableCallIdx, optHit, twoByteDirectCallOk, physAddr, bootHit, overlap);
endinterface

/* mpm_addr_decode.sv */
// combinational decode of a cpu address against the size settings
`timescale 1ns/10ps
module mpm_addr_decode
  import mpm_pkg::*;
(
  mpm_dec_if.dec dif
);
  logic [16:0] romLimit;
  logic [3:0] ramUnits;
  logic [15:0] ramBase;
  logic inRam;

  // ---------------------------------------------------------------
  // size limits
  // ---------------------------------------------------------------
  always_comb begin
    romLimit = {1'b0, dif.romSel[3:0], 12'h000};
    if (dif.ramSel[3:0] <= RAM_SEL_NONE) begin
      ramUnits = RAM_SEL_NONE - dif.ramSel[3:0];
    end else begin
      ramUnits = 4'h0;
    end
    ramBase = RAM_CEIL - {3'h0, ramUnits, 9'h000};
  end

  // ---------------------------------------------------------------
  // region and area decode
  // ---------------------------------------------------------------
  always_comb begin
    dif.inRom = {1'b0, dif.addr} < romLimit;
    inRam = (ramUnits != 4'h0) && (dif.addr >= ramBase) && (dif.addr <= RAM_END);
    dif.overlap = (ramUnits != 4'h0) && (romLimit > {1'b0, ramBase});
    if (dif.inRom) begin
      dif.region = RG_ROM;
    end else if (inRam) begin
      dif.region = RG_XRAM;
    end else if (dif.addr >= SFR_LO) begin
      dif.region = RG_SFR;
    end else if (dif.addr >= HRAM_LO && dif.addr <= HRAM_TOP) begin
      dif.region = RG_HRAM;
    end else begin
      dif.region = RG_NONE;
    end
    dif.block = dif.addr[15:BLOCK_SH];
    dif.vecHit = dif.addr <= VEC_TOP;
    dif.vecIdx = dif.addr[5:1];
    dif.vecHigh = dif.addr[0];
    dif.resetVec = dif.vecHit && (dif.addr[5:1] == 5'h00);
    dif.oneByteTableCallHit = dif.addr >= ONE_BYTE_TABLE_CALL_LO
      && dif.addr <= ONE_BYTE_TABLE_CALL_TOP;
    dif.oneByteTableCallIdx = dif.addr[5:1];
    dif.optHit = (dif.addr >= OPT_LO && dif.addr <= OPT_TOP)
      || (dif.swapOn && dif.addr >= OPT_SWAP_LO && dif.addr <= OPT_SWAP_TOP);
    dif.twoByteDirectCallOk = dif.addr >= TWO_BYTE_DIRECT_CALL_LO
      && dif.addr <= TWO_BYTE_DIRECT_CALL_TOP;
    dif.bootHit = dif.addr <= BOOT0_TOP;
    // boot swap exchanges the two lowest 4 KB clusters
    if (dif.swapOn && dif.addr <= SWAP_TOP) begin
      dif.physAddr = {dif.addr[15:13], ~dif.addr[12], dif.addr[11:0]};
    end else begin
      dif.physAddr = dif.addr;
    end
  end

endmodule // mpm_addr_decode

/* mpm_space_map_props.sv */
// checker for the decode outputs of the program memory space map
`timescale 1ns/10ps
module mpm_space_map_props
  import mpm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [15:0] cpuAddr,
  input wire logic cpuReq,
  input wire logic cpuWr,
  input wire logic [2:0] cpuRegion,
  input wire logic [5:0] cpuBlock,
  input wire logic cpuInRom,
  input wire logic cpuVecHit,
  input wire logic [4:0] cpuVecIdx,
  input wire logic cpuVecHigh,
  input wire logic cpuResetVec,
  input wire logic cpuOneByteTableCallHit,
  input wire logic [4:0] cpuOneByteTableCallIdx,
  input wire logic cpuOptHit,
  input wire logic cpuTwoByteDirectCallOk,
  input wire logic cpuWrRefused,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid
);
  logic directCallIn;
  assign directCallIn = cpuAddr >= TWO_BYTE_DIRECT_CALL_LO
    && cpuAddr <= TWO_BYTE_DIRECT_CALL_TOP;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ----
  // decode relations
  // ----
  a_block_number: assert property (cpuReq |=> cpuBlock == $past(cpuAddr[15:10]))
    else $error("block number wrong");
  a_decode_hold: assert property (!cpuReq |=>
    $stable(cpuBlock) && $stable(cpuVecHit))
    else $error("decode changed without request");
  a_vec_area: assert property (cpuReq |=>
    cpuVecHit == ($past(cpuAddr) <= VEC_TOP))
    else $error("vector area decode wrong");
  a_vec_bytes: assert property (cpuReq && cpuAddr <= VEC_TOP |=>
    cpuVecIdx == $past(cpuAddr[5:1]) && cpuVecHigh == $past(cpuAddr[0]))
    else $error("vector byte order wrong");
  a_reset_shared: assert property (cpuReq |=>
    cpuResetVec == ($past(cpuAddr[15:1]) == 15'h0))
    else $error("reset vector decode wrong");
  a_table_call: assert property (cpuReq && cpuAddr >= ONE_BYTE_TABLE_CALL_LO
    && cpuAddr <= ONE_BYTE_TABLE_CALL_TOP |=>
    cpuOneByteTableCallHit && cpuOneByteTableCallIdx == $past(cpuAddr[5:1]))
    else $error("table call decode wrong");
  a_opt_start: assert property (cpuReq && cpuAddr >= OPT_LO
    && cpuAddr <= OPT_TOP |=> cpuOptHit)
    else $error("option byte decode wrong");
  a_direct_call: assert property (cpuReq |=>
    cpuTwoByteDirectCallOk == $past(directCallIn))
    else $error("direct call area wrong");
  a_refuse_cause: assert property (!(cpuReq && cpuWr && cpuAddr <= BOOT0_TOP) |=>
    !cpuWrRefused)
    else $error("refusal without boot write");
  a_sfr_region: assert property (cpuReq && cpuAddr >= SFR_LO |=>
    cpuRegion == RG_SFR && !cpuInRom)
    else $error("sfr region decode wrong");
  c_reset_vec: cover property (cpuReq && cpuAddr == 16'h0000 ##1 cpuResetVec);
  c_refused: cover property (cpuWrRefused);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_sfr_hit: cover property (cpuReq && cpuAddr >= SFR_LO ##1 cpuRegion == RG_SFR);
endmodule // mpm_space_map_props

bind mpm_space_map mpm_space_map_props u_props (.mclk, .rst_b, .cpuAddr, .cpuReq, .cpuWr,
  .cpuRegion, .cpuBlock, .cpuInRom, .cpuVecHit, .cpuVecIdx, .cpuVecHigh, .cpuResetVec,
  .cpuOneByteTableCallHit, .cpuOneByteTableCallIdx, .cpuOptHit, .cpuTwoByteDirectCallOk,
  .cpuWrRefused, .s_axi_bresp, .s_axi_bvalid);

/* mpm_cpu_model.sv */
// cpu core model issuing program memory addresses
`timescale 1ns/10ps
module mpm_cpu_model (
  input wire logic mclk,
  output logic [15:0] cpuAddr,
  output logic cpuReq,
  output logic cpuWr
);
  initial begin
    cpuAddr = 16'h0000;
    cpuReq = 1'b0;
    cpuWr = 1'b0;
  end
  // one access per edge, back to back; no debugger attached, all user areas free
  task automatic issue(input logic [15:0] a, input logic w);
    cpuAddr <= a;
    cpuReq <= 1'b1;
    cpuWr <= w;
    @(posedge mclk);
  endtask
  // idle bus shows the inverse of the last address
  task automatic rest();
    cpuAddr <= ~cpuAddr;
    cpuReq <= 1'b0;
    cpuWr <= 1'b0;
    @(posedge mclk);
  endtask
endmodule // mpm_cpu_model

/* mpm_space_map_test.sv */
// self-checking bench for the program memory space map
`timescale 1ns/10ps
module mpm_space_map_test;
  import mpm_pkg::*;
  logic mclk, rst_b;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] cpuAddr, cpuPhysAddr;
  logic cpuReq, cpuWr, cpuInRom, cpuVecHit, cpuVecHigh, cpuResetVec, cpuOptHit;
  logic cpuOneByteTableCallHit, cpuTwoByteDirectCallOk, cpuWrRefused, sizeOverlap;
  logic [2:0] cpuRegion;
  logic [5:0] cpuBlock;
  logic [4:0] cpuVecIdx, cpuOneByteTableCallIdx;
  logic [7:0] romv [4] = '{8'hc6, 8'hc8, 8'hcc, 8'hcf};
  logic [7:0] ramv [4] = '{8'h0a, 8'h0a, 8'h08, 8'h08};
  logic [15:0] topv [4] = '{16'h5fff, 16'h7fff, 16'hbfff, 16'hefff};
  int mismatches, total_checks;

  mpm_space_map dut (.*);
  mpm_cpu_model cpu (.mclk, .cpuAddr, .cpuReq, .cpuWr);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // ----
  // access, check and report tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
    @(posedge mclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
    @(posedge mclk);
  endtask
  task automatic look(input logic [15:0] a, input logic w);
    cpu.issue(a, w);
    cpu.rest();
  endtask
  task automatic results();
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    results();
  end
  // ----
  // main sequence
  // ----
  initial begin
    rst_b = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rd(OFS_ROM_SIZE, 32'h0000_00cf, RESP_OKAY);
    rd(OFS_RAM_SIZE, 32'h0000_000c, RESP_OKAY);
    rd(12'h0ff0, 32'h0, RESP_SLVERR);
    wr(12'h0ff0, 32'h1, RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_ROM_SIZE, {24'h0, romv[i]}, RESP_OKAY);
      wr(OFS_RAM_SIZE, {24'h0, ramv[i]}, RESP_OKAY);
      rd(OFS_ROM_SIZE, {24'h0, romv[i]}, RESP_OKAY);
      look(topv[i], 1'b0);
      chk(cpuInRom, 1'b1);
      chk(cpuRegion, RG_ROM);
      look(topv[i] + 16'h0001, 1'b0);
      chk(cpuInRom, 1'b0);
      chk(sizeOverlap, 1'b0);
    end
    chk(cpuRegion, RG_XRAM);
    wr(OFS_RAM_SIZE, 32'h6, RESP_OKAY);
    @(posedge mclk);
    chk(sizeOverlap, 1'b1);
    wr(OFS_RAM_SIZE, 32'h8, RESP_OKAY);
    @(posedge mclk);
    chk(sizeOverlap, 1'b0);
    cpu.issue(16'h0000, 1'b0);
    cpu.issue(16'h0001, 1'b0);
    cpu.rest();
    chk(cpuResetVec, 1'b1);
    chk(cpuVecHigh, 1'b1);
    chk(cpuVecIdx, 5'h00);
    look(16'h003e, 1'b0);
    chk(cpuVecIdx, 5'h1f);
    chk(cpuVecHit, 1'b1);
    chk(cpuResetVec, 1'b0);
    look(16'h0040, 1'b0);
    chk(cpuVecHit, 1'b0);
    chk(cpuOneByteTableCallHit, 1'b1);
    look(16'h007f, 1'b0);
    chk(cpuOneByteTableCallIdx, 5'h1f);
    look(16'h0080, 1'b0);
    chk(cpuOptHit, 1'b1);
    chk(cpuOneByteTableCallHit, 1'b0);
    look(16'h0085, 1'b0);
    chk(cpuOptHit, 1'b0);
    look(16'h1080, 1'b0);
    chk(cpuOptHit, 1'b0);
    look(16'h0800, 1'b0);
    chk(cpuTwoByteDirectCallOk, 1'b1);
    chk(cpuBlock, 6'h02);
    look(16'h07ff, 1'b0);
    chk(cpuTwoByteDirectCallOk, 1'b0);
    chk(cpuBlock, 6'h01);
    look(16'h1000, 1'b0);
    chk(cpuTwoByteDirectCallOk, 1'b0);
    look(16'hfb00, 1'b0);
    chk(cpuRegion, RG_HRAM);
    chk(cpuInRom, 1'b0);
    chk(cpuBlock, 6'h3e);
    look(16'hff00, 1'b0);
    chk(cpuRegion, RG_SFR);
    wr(OFS_CTRL, 32'h2, RESP_OKAY);
    look(16'h1080, 1'b0);
    chk(cpuOptHit, 1'b1);
    chk(cpuPhysAddr, 16'h0080);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    look(16'h0fff, 1'b1);
    chk(cpuWrRefused, 1'b1);
    look(16'h1000, 1'b1);
    chk(cpuWrRefused, 1'b0);
    look(16'h0fff, 1'b0);
    chk(cpuWrRefused, 1'b0);
    rd(OFS_STATUS, 32'h0001_0103, RESP_OKAY);
    rd(OFS_REFUSED, 32'h1, RESP_OKAY);
    wr(OFS_STATUS, 32'h0001_0000, RESP_OKAY);
    rd(OFS_STATUS, 32'h0000_0103, RESP_OKAY);
    wr(OFS_REFUSED, 32'h0, RESP_OKAY);
    rd(OFS_REFUSED, 32'h0, RESP_OKAY);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    look(16'h0000, 1'b1);
    chk(cpuWrRefused, 1'b0);
    rst_b <= 1'b0;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rd(OFS_ROM_SIZE, 32'h0000_00cf, RESP_OKAY);
    rd(OFS_RAM_SIZE, 32'h0000_000c, RESP_OKAY);
    rd(OFS_CTRL, 32'h0, RESP_OKAY);
    results();
  end
endmodule // mpm_space_map_test
